/* File: verilog/csc_clock_select.sv */
// Clock select control register, tach filters, PWM base and sync pulse
//
// Overview of operation
// - Extend bit selects five-stage tach voting filter
// - Extension covers all eight inputs always
// - Reset clears filter extend bit
// - Bits 5:4 pick common PWM base divider
// - Encodings give divide by 3/15/75/375
// - Reset clears PWM divider select
// - Sync pulse at period end realigns dividers
// - First asserter sets period, others follow
// - Period field spans 2 to 16 seconds
// - Sync needs strap high and nonzero period
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module csc_clock_select
  import csc_pkg::*;
#(
  parameter longint SYNC_UNIT_CYC  = CSC_SYNC_UNIT_CYC,
  parameter int     TACH_N         = CSC_TACH_N
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       srst_i,
  input  wire logic [csc_pkg::CSC_ADDR_W-1:0] reg_addr_i,
  input  wire logic [csc_pkg::CSC_DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [csc_pkg::CSC_DATA_W-1:0] reg_rdata_o,
  input  wire logic [TACH_N-1:0]          tach_raw_i,
  output logic      [TACH_N-1:0]          tach_filt_o,
  input  wire logic                       sync_enable_strap_i,
  input  wire logic                       sync_n_i,
  output logic                            sync_n_o,
  output logic                            sync_n_oe_o,
  output logic      [1:0]                 pwm_divider_select_o,
  output logic                            pwm_base_tick_o,
  output logic                            realign_o
);
  import csc_pkg::*;

  // Register state
  logic       tach_filter_extend_q, tach_filter_extend_d;
  logic [1:0] pwm_divider_select_q, pwm_divider_select_d;
  logic [3:0] sync_period_q, sync_period_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] reg_value;

  // Shared by the write and read decode
  function automatic logic reg_hit(input logic [CSC_ADDR_W-1:0] addr);
    return addr == CSC_REG_OFFSET;
  endfunction

  always_comb begin
    tach_filter_extend_d = tach_filter_extend_q;
    pwm_divider_select_d = pwm_divider_select_q;
    sync_period_d        = sync_period_q;
    reg_value = {tach_filter_extend_q, 1'b0, pwm_divider_select_q,
                 sync_period_q} & CSC_WRITE_MASK;
    rdata_d = '0;
    if (reg_wr_i && reg_hit(reg_addr_i)) begin
      tach_filter_extend_d = reg_wdata_i[CSC_TFE_BIT];
      pwm_divider_select_d =
        reg_wdata_i[CSC_PDS_MSB:CSC_PDS_LSB];
      sync_period_d = reg_wdata_i[CSC_SP_MSB:CSC_SP_LSB];
    end
    // Unmapped addresses read as zero
    if (reg_rd_i && reg_hit(reg_addr_i)) rdata_d = reg_value;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tach_filter_extend_q <= CSC_RESET_VALUE[CSC_TFE_BIT];
      pwm_divider_select_q <=
        CSC_RESET_VALUE[CSC_PDS_MSB:CSC_PDS_LSB];
      sync_period_q <= CSC_RESET_VALUE[CSC_SP_MSB:CSC_SP_LSB];
      rdata_q       <= '0;
    end else begin
      tach_filter_extend_q <= tach_filter_extend_d;
      pwm_divider_select_q <= pwm_divider_select_d;
      sync_period_q        <= sync_period_d;
      rdata_q              <= rdata_d;
    end
  end

  // Filter sample tick
  logic [7:0] ftick_q, ftick_d;
  logic       ftick;
  assign ftick = (ftick_q == 8'(CSC_FILT_TICK_CYC - 1));

  always_comb begin
    ftick_d = ftick ? 8'h00 : ftick_q + 8'h01;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) ftick_q <= '0;
    else        ftick_q <= ftick_d;
  end

  // Filter bank ignores whether tach counting is used at all
  for (genvar i = 0; i < TACH_N; i++) begin : g_filt
    csc_vote_filter #(
      .DEPTH (CSC_FILT_LONG)
    ) u_filt (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .tick_i     (ftick),
      .extend_i   (tach_filter_extend_q),
      .raw_i      (tach_raw_i[i]),
      .filt_o     (tach_filt_o[i])
    );
  end

  // Sync line sensing; pin treated as synchronous, one stage for edges
  logic sync_seen_q, sync_seen_d;
  logic sync_fall;
  csc_sync_state_type state_q, state_d;
  logic [39:0] per_cnt_q, per_cnt_d;
  logic [39:0] per_limit;
  logic [7:0]  pulse_cnt_q, pulse_cnt_d;
  logic        drive_q, drive_d;
  logic        realign_q, realign_d;
  logic        sync_on;

  assign sync_on   = sync_enable_strap_i && (sync_period_q != 4'h0);
  // Field n counts (n + 1) units: 2 units at 1 up to 16 units at 15
  assign per_limit = 40'(SYNC_UNIT_CYC)
                   * (40'(sync_period_q) + 40'h1);
  // Own drive excluded: a falling edge we did not cause is a peer's pulse
  assign sync_fall = sync_seen_q && !sync_n_i;

  always_comb begin
    state_d     = state_q;
    per_cnt_d   = per_cnt_q;
    pulse_cnt_d = pulse_cnt_q;
    drive_d     = drive_q;
    realign_d   = 1'b0;
    sync_seen_d = sync_n_i;
    case (state_q)
      CSC_SYNC_IDLE: begin
        if (!sync_on) begin
          per_cnt_d = '0;
        end else if (sync_fall) begin
          per_cnt_d = '0; // Follow the first asserter
          realign_d = 1'b1;
          state_d   = CSC_SYNC_WAIT;
        end else if (per_cnt_q >= per_limit - 40'h1) begin
          per_cnt_d   = '0;
          drive_d     = 1'b1; // Pull line low at period end
          pulse_cnt_d = '0;
          realign_d   = 1'b1;
          state_d     = CSC_SYNC_DRIVE;
        end else begin
          per_cnt_d = per_cnt_q + 40'h1;
        end
      end
      CSC_SYNC_DRIVE: begin
        // Period keeps running under the pulse so it stays exact
        if (sync_on) per_cnt_d = per_cnt_q + 40'h1;
        if (pulse_cnt_q >= 8'(CSC_SYNC_PULSE_CYC - 1)) begin
          drive_d = 1'b0; // Release; pull-up restores high
          state_d = CSC_SYNC_WAIT;
        end else begin
          pulse_cnt_d = pulse_cnt_q + 8'h01;
        end
      end
      CSC_SYNC_WAIT: begin
        // Hold off until the line is high again, counting from pulse
        if (sync_n_i) state_d = CSC_SYNC_IDLE;
        if (sync_on) per_cnt_d = per_cnt_q + 40'h1;
      end
      default: begin
        drive_d = 1'b0;
        state_d = CSC_SYNC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q     <= CSC_SYNC_IDLE;
      per_cnt_q   <= '0;
      pulse_cnt_q <= '0;
      drive_q     <= 1'b0;
      realign_q   <= 1'b0;
      sync_seen_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      per_cnt_q   <= per_cnt_d;
      pulse_cnt_q <= pulse_cnt_d;
      drive_q     <= drive_d;
      realign_q   <= realign_d;
      sync_seen_q <= sync_seen_d;
    end
  end

  csc_pwm_base u_pwm (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .realign_i  (realign_q),
    .sel_i      (pwm_divider_select_q),
    .tick_o     (pwm_base_tick_o)
  );

  assign reg_rdata_o          = rdata_q;
  assign sync_n_o             = 1'b0; // Only ever drives low
  assign sync_n_oe_o          = drive_q;
  assign pwm_divider_select_o = pwm_divider_select_q;
  assign realign_o            = realign_q;
endmodule

/* File: verilog/csc_pkg.sv */
// Package: register map, field layout and timing constants for clock select
package csc_pkg;
  localparam int          CSC_ADDR_W       = 8;
  localparam int          CSC_DATA_W       = 8;
  localparam logic [7:0]  CSC_REG_OFFSET   = 8'hfd;
  localparam logic [7:0]  CSC_RESET_VALUE  = 8'h00;
  localparam int          CSC_TFE_BIT      = 7;
  localparam int          CSC_PDS_LSB      = 4;
  localparam int          CSC_PDS_MSB      = 5;
  localparam int          CSC_SP_LSB       = 0;
  localparam int          CSC_SP_MSB       = 3;
  localparam logic [7:0]  CSC_WRITE_MASK   = 8'hbf;
  localparam int          CSC_TACH_N       = 8;
  localparam int          CSC_FILT_SHORT   = 2;
  localparam int          CSC_FILT_LONG    = 5;
  // Filter sample tick; five stages at 100 ns span about 300 ns more than two
  localparam int          CSC_CLK_MHZ      = 200;
  localparam int          CSC_FILT_TICK_NS = 100;
  localparam int          CSC_FILT_TICK_CYC =
    (CSC_FILT_TICK_NS * CSC_CLK_MHZ) / 1000;
  // PWM base divides
  localparam logic [8:0]  CSC_PWM_DIV0     = 9'h003;
  localparam logic [8:0]  CSC_PWM_DIV1     = 9'h00f;
  localparam logic [8:0]  CSC_PWM_DIV2     = 9'h04b;
  localparam logic [8:0]  CSC_PWM_DIV3     = 9'h177;
  // Sync period: field value n gives (n + 1) s, 2 s at 1 up to 16 s at 15
  localparam longint      CSC_SYNC_MAX_S   = 16;
  localparam longint      CSC_SYNC_STEPS   = 15;
  localparam longint      CSC_SYNC_UNIT_CYC =
    (CSC_SYNC_MAX_S * CSC_CLK_MHZ * 1000000) / (CSC_SYNC_STEPS + 1);
  localparam int          CSC_SYNC_PULSE_NS = 100;
  localparam int          CSC_SYNC_PULSE_CYC =
    (CSC_SYNC_PULSE_NS * CSC_CLK_MHZ) / 1000;
  typedef enum logic [1:0] {
    CSC_SYNC_IDLE  = 2'b00,
    CSC_SYNC_DRIVE = 2'b01,
    CSC_SYNC_WAIT  = 2'b11
  } csc_sync_state_type;
endpackage

/* File: verilog/csc_vote_filter.sv */
// One tachometer input voting filter with selectable depth
`timescale 1ns/100ps
module csc_vote_filter
  import csc_pkg::*;
#(
  parameter int DEPTH = CSC_FILT_LONG
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic tick_i,
  input  wire logic extend_i,
  input  wire logic raw_i,
  output logic      filt_o
);
  logic [DEPTH-1:0] hist_q, hist_d;
  logic             filt_q, filt_d;
  logic [CSC_FILT_SHORT-1:0] short_win;

  always_comb begin
    hist_d    = hist_q;
    filt_d    = filt_q;
    short_win = hist_q[CSC_FILT_SHORT-1:0];
    if (tick_i) begin
      hist_d = {hist_q[DEPTH-2:0], raw_i};
      // Output moves only when all five stages agree, or the newest two with extend clear
      if (extend_i) begin
        if (&hist_q) filt_d = 1'b1;
        else if (~|hist_q) filt_d = 1'b0;
      end else begin
        if (&short_win) filt_d = 1'b1;
        else if (~|short_win) filt_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hist_q <= '1;
      filt_q <= 1'b1;
    end else begin
      hist_q <= hist_d;
      filt_q <= filt_d;
    end
  end

  assign filt_o = filt_q;
endmodule

/* File: verilog/csc_pwm_base.sv */
// PWM base clock divider producing a one-cycle enable pulse
`timescale 1ns/100ps
module csc_pwm_base
  import csc_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic       realign_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [8:0] cnt_q, cnt_d;
  logic       tick_q, tick_d;
  logic [8:0] limit;

  always_comb begin
    case (sel_i)
      2'b00:   limit = CSC_PWM_DIV0;
      2'b01:   limit = CSC_PWM_DIV1;
      2'b10:   limit = CSC_PWM_DIV2;
      default: limit = CSC_PWM_DIV3;
    endcase
    tick_d = 1'b0;
    if (realign_i) begin
      cnt_d = '0; // Divider restarts on a sync pulse
    end else if (cnt_q >= limit - 9'h001) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 9'h001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule

/* File: verification/csc_clock_select_props.sv */
// Port assertions for the clock select block
`timescale 1ns/100ps
module csc_clock_select_props (
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_rdata_o,
  input  wire logic       sync_enable_strap_i,
  input  wire logic       sync_n_o,
  input  wire logic       sync_n_oe_o,
  input  wire logic [1:0] pwm_divider_select_o,
  input  wire logic       pwm_base_tick_o,
  input  wire logic       realign_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  rdata_idle_a:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read");
  rdata_value_a:
    assert property (reg_rd_i && reg_addr_i == 8'hfd |=> !reg_rdata_o[6]
      && reg_rdata_o[5:4] == $past(pwm_divider_select_o))
    else $error("read data differs from divider select");
  unmapped_read_a:
    assert property (reg_rd_i && reg_addr_i != 8'hfd |=> reg_rdata_o == 0)
    else $error("unmapped read not zero");
  div_write_a:
    assert property (reg_wr_i && reg_addr_i == 8'hfd |=>
      pwm_divider_select_o == $past(reg_wdata_i[5:4]))
    else $error("divider select not written");
  div_hold_a:
    assert property (!(reg_wr_i && reg_addr_i == 8'hfd) |=>
      $stable(pwm_divider_select_o))
    else $error("divider select changed without write");
  tick_gap_a:
    assert property (pwm_base_tick_o |=> !pwm_base_tick_o [*2])
    else $error("base ticks closer than three cycles");
  drive_low_a:
    assert property (sync_n_o == 1'b0)
    else $error("sync line driven high");
  pulse_realign_a:
    assert property ($rose(sync_n_oe_o) |-> realign_o)
    else $error("own pulse without realign");
  pulse_width_a:
    assert property ($rose(sync_n_oe_o) |-> ##20 $fell(sync_n_oe_o))
    else $error("sync pulse width wrong");
  strap_off_a:
    assert property (!sync_enable_strap_i |=> !$rose(sync_n_oe_o))
    else $error("pulse with strap low");
endmodule
bind csc_clock_select csc_clock_select_props u_props (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .sync_enable_strap_i(sync_enable_strap_i),
  .sync_n_o(sync_n_o), .sync_n_oe_o(sync_n_oe_o),
  .pwm_divider_select_o(pwm_divider_select_o),
  .pwm_base_tick_o(pwm_base_tick_o), .realign_o(realign_o));

/* File: verification/csc_peer_model.sv */
// Peer controller on the shared pulled-up sync line
`timescale 1ns/100ps
module csc_peer_model (
  input  wire logic core_clk_i,
  input  wire logic pull_i,
  input  wire logic dut_oe_i,
  input  wire logic dut_data_i,
  output logic      line_o
);
  logic [4:0] hold_q = 5'h00;
  // Pulses only when told; each pull holds the line low for 20 cycles
  always @(posedge core_clk_i)
    if (pull_i) hold_q <= 5'h14;
    else if (hold_q != 5'h00) hold_q <= hold_q - 5'h01;
  // Pull-up wins unless a party sinks the line
  assign line_o = (hold_q == 5'h00) && (dut_oe_i ? dut_data_i : 1'b1);
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the clock select block
`timescale 1ns/100ps
module tb;
  import csc_pkg::*;
  logic       clk = 0, srst = 1, wr = 0, rd = 0, strap = 0, pull = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, raw = 8'h00, filt;
  logic [1:0] psel;
  logic       line, oe, drv, tick, realign;
  int         err_count = 0, samples_checked = 0, n;
  int         divs [4] = '{3, 15, 75, 375};
  always #2.5 clk = ~clk;
  localparam int SYNC_UNIT = 10;
  csc_clock_select #(.SYNC_UNIT_CYC(SYNC_UNIT)) dut (.core_clk_i(clk),
    .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .tach_raw_i(raw), .tach_filt_o(filt),
    .sync_enable_strap_i(strap), .sync_n_i(line), .sync_n_o(drv),
    .sync_n_oe_o(oe), .pwm_divider_select_o(psel),
    .pwm_base_tick_o(tick), .realign_o(realign));
  csc_peer_model peer (.core_clk_i(clk), .pull_i(pull), .dut_oe_i(oe),
    .dut_data_i(drv), .line_o(line));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, exp);
  endtask
  // Waits for oe, tick or realign by sel; c counts edges passed
  task automatic wait_sig(input int sel, input int lim, output int c);
    c = 0;
    while ((sel == 0 ? oe : sel == 1 ? tick : realign) !== 1'b1
           && c < lim) begin
      @(posedge clk);
      #1 c++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 0;
    rd_reg(8'hfd, 8'h00);
    wr_reg(8'hfd, 8'hff);
    wr_reg(8'hfc, 8'h00);
    rd_reg(8'hfd, 8'hbf);
    rd_reg(8'hfc, 8'h00);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'hfd, 8'(i << 4));
      #1 wait_sig(1, 400, n);
      @(posedge clk);
      #1 wait_sig(1, 400, n);
      chk(16'(n + 1), 16'(divs[i]));
      chk(psel, 16'(i));
    end
    $display("divider test done");
    chk(filt, 8'h00);
    wr_reg(8'hfd, 8'h80);
    raw <= 8'hff;
    repeat (60) @(posedge clk);
    #1 chk(filt, 8'h00);
    repeat (80) @(posedge clk);
    #1 chk(filt, 8'hff);
    $display("filter test done");
    @(posedge clk);
    strap <= 1;
    wait_sig(0, 300, n);
    chk(oe, 1'b0);
    wr_reg(8'hfd, 8'h03);
    #1 wait_sig(0, 100, n);
    chk({oe, realign, line}, 3'b110);
    repeat (20) @(posedge clk);
    #1 wait_sig(0, 100, n);
    chk(16'(n + 20), 16'((3 + 1) * SYNC_UNIT));
    @(posedge clk);
    strap <= 0;
    repeat (25) @(posedge clk);
    #1 wait_sig(0, 300, n);
    chk(oe, 1'b0);
    wr_reg(8'hfd, 8'h0f);
    strap <= 1;
    repeat (50) @(posedge clk);
    pull <= 1;
    @(posedge clk);
    pull <= 0;
    #1 wait_sig(2, 5, n);
    chk({realign, oe}, 2'b10);
    wait_sig(0, 120, n);
    chk(oe, 1'b0);
    $display("sync test done");
    wr_reg(8'hfd, 8'hb0);
    rd_reg(8'hfd, 8'hb0);
    @(posedge clk);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    rd_reg(8'hfd, 8'h00);
    chk({psel, oe}, 3'b000);
    $display("reset test done");
    end_sim;
  end
endmodule
